// ### pmc_pkg.sv
// package: register map, field positions and types for power mode control
package pmc_pkg;
  localparam logic [11:0] CTL_OFFSET     = 12'h000;
  localparam logic [11:0] STATUS_OFFSET  = 12'h004;
  localparam logic [31:0] CTL_RESET      = 32'h0000_8000;
  localparam logic [31:0] CTL_RW_MASK    = 32'h0034_c1f3;
  localparam logic [31:0] UV_FIELD_MASK  = 32'h0000_00f0;
  localparam int          BANK3_BIT      = 21;
  localparam int          BANK2_BIT      = 20;
  localparam int          LOW_DRIVE_BIT  = 18;
  localparam int          OV_THR_BIT     = 15;
  localparam int          OV_EN_BIT      = 14;
  localparam int          BKP_WEN_BIT    = 8;
  localparam int          UV_THR_LSB     = 5;
  localparam int          UV_EN_BIT      = 4;
  localparam int          STB_CLR_BIT    = 3;
  localparam int          WU_CLR_BIT     = 2;
  localparam int          STB_SEL_BIT    = 1;
  localparam int          LOW_POWER_BIT  = 0;
  localparam int          ST_WU_BIT      = 0;
  localparam int          ST_STB_BIT     = 1;

  typedef enum logic [1:0] {
    PMC_RUN   = 2'b00,
    PMC_DEEP  = 2'b01,
    PMC_STBY  = 2'b11
  } pmc_mode_t;

  typedef struct packed {
    logic       bank_three_retention_off;
    logic       bank_two_retention_off;
    logic       regulator_low_drive_enable;
    logic       regulator_low_power;
    logic       overvoltage_threshold_select;
    logic       overvoltage_detector_enable;
    logic [2:0] undervoltage_threshold_select;
    logic       undervoltage_detector_enable;
    logic       backup_domain_write_enable;
  } pmc_ctrl_t;
endpackage : pmc_pkg

// ### pmc_flag.sv
// sticky status flag: set wins over clear
`timescale 1ns/100ps
module pmc_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output logic      flag
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    set_evt |=> flag) else $error("flag set lost");
  a_clr_works: assert property (@(posedge pclk) disable iff (!presetn)
    clr_evt && !set_evt |=> !flag) else $error("flag clear lost");
endmodule : pmc_flag

// ### pmc_ctl.sv
// power mode control register with apb slave and mode outputs
//
// Contract
// - control word at offset 0x00, resets to 0x00008000, also after standby.
// - half-word and word accesses are accepted.
// - bit 21 set powers off the third sram bank in deep-sleep.
// - bit 20 set powers off the second sram bank in deep-sleep.
// - bit 18 selects low-drive regulator in deep-sleep.
// - bit 15 selects over-voltage threshold, 0 for 5V, 1 for 5.5V.
// - bit 14 enables the over-voltage detector.
// - bit 8 clear blocks all backup-domain writes.
// - bits 7:5 pick the under-voltage threshold, 2.9V up to 4.6V.
// - bit 4 enables the under-voltage detector.
// - lock input freezes under-voltage enable and threshold.
// - writing 1 to bit 3 clears standby flag; reads zero.
// - writing 1 to bit 2 clears wakeup flag; reads zero.
// - bit 1 picks standby over deep-sleep on core deep sleep.
// - bit 0 selects low-power regulator in deep-sleep.
// - running oscillator user forces regulator back to normal power.
// - standby flag set after standby, cleared by por or strobe.
// - wakeup flag set by pin or alarm, cleared by reset or strobe.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module pmc_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        undervoltage_config_lock,
  input  wire logic        core_deep_sleep_request,
  input  wire logic        internal_rc_oscillator,
  input  wire logic        standby_exit,
  input  wire logic        wakeup_event,
  input  wire logic        backup_write_req,
  output logic             backup_write_strobe,
  output pmc_pkg::pmc_ctrl_t ctrl,
  output pmc_pkg::pmc_mode_t mode,
  output logic             regulator_low_power_active,
  output logic             standby_status_flag,
  output logic             wakeup_status_flag
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctl;
  logic        setup;
  logic        access;
  logic        wr_ctl;
  logic        wr_bad;
  logic [31:0] lane;
  logic [31:0] wmask;
  logic        stb_clr;
  logic        wu_clr;
  logic        stb_raw;

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  function automatic logic width_ok(input logic [3:0] s);
    width_ok = (s == 4'hf) || (s == 4'h3) || (s == 4'hc);
  endfunction : width_ok

  // byte writes refused: only half-word or word lanes are legal
  assign setup  = psel && !penable;
  // write lands only where the master sees pready high
  assign access = psel && penable && pready;
  assign lane   = lane_mask(pstrb);
  assign wr_ctl = access && pwrite && paddr == pmc_pkg::CTL_OFFSET
                  && width_ok(pstrb);
  assign wr_bad = setup && pwrite && !(paddr == pmc_pkg::CTL_OFFSET
                  && width_ok(pstrb));

  always_comb begin
    wmask = lane & pmc_pkg::CTL_RW_MASK;
    if (undervoltage_config_lock) begin
      wmask = wmask & ~pmc_pkg::UV_FIELD_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait, answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && (wr_bad || (!pwrite &&
                 paddr != pmc_pkg::CTL_OFFSET &&
                 paddr != pmc_pkg::STATUS_OFFSET));
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite && paddr == pmc_pkg::CTL_OFFSET) begin
        prdata <= ctl & pmc_pkg::CTL_RW_MASK;
      end else if (setup && !pwrite && paddr == pmc_pkg::STATUS_OFFSET) begin
        prdata[pmc_pkg::ST_STB_BIT] <= standby_status_flag;
        prdata[pmc_pkg::ST_WU_BIT]  <= wakeup_status_flag;
      end
    end
  end

  // system reset covers wakeup from standby as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= pmc_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= (ctl & ~wmask) | (pwdata & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_clr <= 1'b0;
      wu_clr  <= 1'b0;
    end else begin
      stb_clr <= wr_ctl && lane[pmc_pkg::STB_CLR_BIT]
                 && pwdata[pmc_pkg::STB_CLR_BIT];
      wu_clr  <= wr_ctl && lane[pmc_pkg::WU_CLR_BIT]
                 && pwdata[pmc_pkg::WU_CLR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      ctrl.overvoltage_threshold_select <= 1'b1;
    end else begin
      ctrl.bank_three_retention_off   <= ctl[pmc_pkg::BANK3_BIT];
      ctrl.bank_two_retention_off     <= ctl[pmc_pkg::BANK2_BIT];
      ctrl.regulator_low_drive_enable <= ctl[pmc_pkg::LOW_DRIVE_BIT];
      ctrl.overvoltage_threshold_select <= ctl[pmc_pkg::OV_THR_BIT];
      ctrl.overvoltage_detector_enable  <= ctl[pmc_pkg::OV_EN_BIT];
      ctrl.undervoltage_threshold_select <=
        ctl[pmc_pkg::UV_THR_LSB +: 3];
      ctrl.undervoltage_detector_enable <= ctl[pmc_pkg::UV_EN_BIT];
      ctrl.backup_domain_write_enable   <= ctl[pmc_pkg::BKP_WEN_BIT];
      ctrl.regulator_low_power          <= ctl[pmc_pkg::LOW_POWER_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode                       <= pmc_pkg::PMC_RUN;
      regulator_low_power_active <= 1'b0;
      backup_write_strobe        <= 1'b0;
    end else begin
      if (!core_deep_sleep_request) begin
        mode <= pmc_pkg::PMC_RUN;
      end else if (ctl[pmc_pkg::STB_SEL_BIT]) begin
        mode <= pmc_pkg::PMC_STBY;
      end else begin
        mode <= pmc_pkg::PMC_DEEP;
      end
      // oscillator user keeps the regulator at full power
      regulator_low_power_active <= core_deep_sleep_request
        && !ctl[pmc_pkg::STB_SEL_BIT] && ctl[pmc_pkg::LOW_POWER_BIT]
        && !internal_rc_oscillator;
      backup_write_strobe <= backup_write_req
        && ctl[pmc_pkg::BKP_WEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby flag survives system reset, only power-on reset or the bit 3 strobe clears it
  assign stb_raw = standby_exit;
  pmc_flag u_stb_flag (
    .pclk    (pclk),
    .presetn (por_resetn),
    .set_evt (stb_raw),
    .clr_evt (stb_clr),
    .flag    (standby_status_flag)
  );
  pmc_flag u_wu_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (wakeup_event),
    .clr_evt (wu_clr),
    .flag    (wakeup_status_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_lock_holds_uv: assert property (@(posedge pclk) disable iff (!presetn)
    undervoltage_config_lock |=> $stable(ctl[7:4]))
    else $error("locked field changed");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl & ~pmc_pkg::CTL_RW_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  a_backup_gate: assert property (@(posedge pclk) disable iff (!presetn)
    backup_write_strobe |-> $past(ctl[pmc_pkg::BKP_WEN_BIT]))
    else $error("backup write passed while disabled");
  a_mode_select: assert property (@(posedge pclk) disable iff (!presetn)
    core_deep_sleep_request && ctl[1] && $stable(ctl[1])
    |=> mode == pmc_pkg::PMC_STBY)
    else $error("standby not entered");
  a_osc_override: assert property (@(posedge pclk) disable iff (!presetn)
    internal_rc_oscillator |=> !regulator_low_power_active)
    else $error("low power kept with oscillator in use");
  a_strobe_clears: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && pstrb[0] && pwdata[2] && !wakeup_event ##1 !wakeup_event
    |=> !wakeup_status_flag)
    else $error("wakeup flag not cleared");
  a_byte_refused: assert property (@(posedge pclk) disable iff (!presetn)
    setup && pwrite && !width_ok(pstrb) |=> $stable(ctl) && pslverr)
    else $error("byte write accepted");
  a_ov_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ctrl.overvoltage_detector_enable == $past(ctl[14]))
    else $error("ov enable lags");
endmodule : pmc_ctl

// ### tb_pmc_ctl.sv
// testbench: apb register checks for power mode control
`timescale 1ns/100ps
module tb_pmc_ctl;
  logic pclk, presetn, por_resetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, err, lock, deep_req, rc_osc, stb_exit, wu_evt;
  logic bkp_req, bkp_strobe, lp_active, stb_flag, wu_flag;
  pmc_pkg::pmc_ctrl_t ctrl;
  pmc_pkg::pmc_mode_t mode;
  int bad_count = 0;
  int compares = 0;
  pmc_ctl u_pmc_ctl (.pclk(pclk), .presetn(presetn), .por_resetn(por_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .undervoltage_config_lock(lock),
    .core_deep_sleep_request(deep_req), .internal_rc_oscillator(rc_osc),
    .standby_exit(stb_exit), .wakeup_event(wu_evt),
    .backup_write_req(bkp_req), .backup_write_strobe(bkp_strobe),
    .ctrl(ctrl), .mode(mode), .regulator_low_power_active(lp_active),
    .standby_status_flag(stb_flag), .wakeup_status_flag(wu_flag));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // idle edge first so no signal is assigned twice in one step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready mid-cycle, then finish on the edge that samples it
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial begin
    wt(5000);
    bad_count++;
    end_sim();
  end
  initial begin
    presetn = 1'b0; por_resetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    lock = 1'b0; deep_req = 1'b0; rc_osc = 1'b0; stb_exit = 1'b0;
    wu_evt = 1'b0; bkp_req = 1'b0;
    wt(3);
    presetn <= 1'b1; por_resetn <= 1'b1;
    apb(0, 12'h000, 0, 4'hf);
    chk("reset", rd, 32'h0000_8000);
    chk("rst_ovthr", ctrl.overvoltage_threshold_select, 1);
    apb(1, 12'h000, 32'hffff_ffff, 4'hf);
    wt(2);
    chk("ctrl_all", ctrl, 32'h7ff);
    apb(0, 12'h000, 0, 4'hf);
    chk("rw_mask", rd, 32'h0034_c1f3);
    $display("test word access done");
    apb(1, 12'h000, 0, 4'h3);
    apb(0, 12'h000, 0, 4'hf);
    chk("half_lo", rd, 32'h0034_0000);
    apb(1, 12'h000, 0, 4'hc);
    apb(0, 12'h000, 0, 4'hf);
    chk("half_hi", rd, 32'h0);
    apb(1, 12'h000, 32'hffff_ffff, 4'h1);
    chk("bad_strb_err", err, 1);
    apb(0, 12'h000, 0, 4'hf);
    chk("bad_strb", rd, 32'h0);
    $display("test half word done");
    apb(1, 12'h000, 32'h0000_00a0, 4'hf);
    lock <= 1'b1;
    apb(1, 12'h000, 32'h0000_0150, 4'hf);
    apb(0, 12'h000, 0, 4'hf);
    chk("locked", rd, 32'h0000_01a0);
    lock <= 1'b0;
    apb(1, 12'h000, 32'h0, 4'hf);
    apb(0, 12'h000, 0, 4'hf);
    chk("unlocked", rd, 32'h0);
    $display("test lock done");
    bkp_req <= 1'b1;
    wt(3);
    chk("bkp_blocked", bkp_strobe, 0);
    apb(1, 12'h000, 32'h0000_0100, 4'hf);
    wt(3);
    chk("bkp_pass", bkp_strobe, 1);
    bkp_req <= 1'b0;
    $display("test backup gate done");
    stb_exit <= 1'b1; wu_evt <= 1'b1;
    wt(1);
    stb_exit <= 1'b0; wu_evt <= 1'b0;
    wt(2);
    apb(0, 12'h004, 0, 4'hf);
    chk("status", rd[1:0], 2'b11);
    apb(1, 12'h000, 32'h0, 4'hf);
    wt(2);
    chk("no_clr", {stb_flag, wu_flag}, 2'b11);
    apb(1, 12'h000, 32'h0000_0008, 4'hf);
    wt(2);
    chk("stb_clr", {stb_flag, wu_flag}, 2'b01);
    apb(1, 12'h000, 32'h0000_0004, 4'hf);
    wt(2);
    chk("wu_clr", wu_flag, 0);
    $display("test flags done");
    apb(1, 12'h000, 32'h0000_0001, 4'hf);
    deep_req <= 1'b1;
    wt(3);
    chk("mode_deep", mode, pmc_pkg::PMC_DEEP);
    chk("lp_on", lp_active, 1);
    rc_osc <= 1'b1;
    wt(3);
    chk("lp_rc", lp_active, 0);
    rc_osc <= 1'b0;
    apb(1, 12'h000, 32'h0000_0003, 4'hf);
    wt(3);
    chk("mode_stby", mode, pmc_pkg::PMC_STBY);
    deep_req <= 1'b0;
    wt(3);
    chk("mode_run", mode, pmc_pkg::PMC_RUN);
    apb(0, 12'h008, 0, 4'hf);
    chk("unmapped_err", err, 1);
    chk("unmapped_rd", rd, 32'h0);
    $display("test modes done");
    apb(1, 12'h000, 32'hffff_ffff, 4'hf);
    stb_exit <= 1'b1; wu_evt <= 1'b1;
    wt(1);
    stb_exit <= 1'b0; wu_evt <= 1'b0;
    wt(2);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    apb(0, 12'h000, 0, 4'hf);
    chk("rerst", rd, 32'h0000_8000);
    chk("rerst_flags", {stb_flag, wu_flag}, 2'b10);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_pmc_ctl
